// [common/timing_pkg.sv]
// Shared types and constants for the instruction cycle sequencer.
// Assumes one system clock and a synchronous active-low reset.
package timing_pkg;

  // Cycle counts fit four bits; no instruction needs more than eight
  localparam int CYC_W = 4;
  localparam logic [3:0] CYC_MAX = 4'h8;
  localparam logic [3:0] CYC_ONE = 4'h1;

  // Stack pointer after reset
  localparam logic [7:0] SP_RESET = 8'h07;
  localparam logic [7:0] SP_STEP = 8'h01;

  // Opcodes with side effects inside the sequencer
  localparam logic [7:0] OP_PUSH = 8'hc0;
  localparam logic [7:0] OP_POP = 8'hd0;
  localparam logic [6:0] OP_XCHD_HI = 7'h6b;

  // Nibble field split
  localparam int NIB_HI = 7;
  localparam int NIB_LO = 4;

  typedef struct packed {
    logic [1:0] bytes;
    logic [CYC_W-1:0] cycles;
    logic cond;
  } timing_info_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [1:0] bytes;
    logic [CYC_W-1:0] cycles;
    logic taken;
  } instr_t;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] ram;
  } nibble_xchg_t;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b01,
    ST_EXEC = 2'b10
  } seq_state_t;

endpackage

// [logic/cycle_countdown.sv]
// Down counter that paces the execute phase of one instruction.
// Assumes the loader only loads while the count has run out.
`timescale 1ns/1ps
module cycle_countdown
  import timing_pkg::*;
#(
  parameter int W = CYC_W
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Load
  input wire logic i_load,
  input wire logic [W-1:0] i_count,
  // State
  output logic [W-1:0] o_remaining,
  output logic o_last
);

  logic [W-1:0] remaining_q;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      remaining_q <= '0;
    end else if (i_load) begin
      remaining_q <= i_count;
    end else if (remaining_q != '0) begin
      remaining_q <= remaining_q - W'(1);
    end
  end

  assign o_remaining = remaining_q;
  assign o_last = (remaining_q == W'(1));

endmodule

// [logic/instr_sequencer.sv]
// Instruction cycle sequencer: decides how many clocks each
// instruction executes for and paces fetch against that count.
// Assumes opcodes and the branch outcome come from logic on i_mclk.
`timescale 1ns/1ps
module instr_sequencer
  import timing_pkg::*;
(
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // Opcode fetch
  input wire logic i_fetch_valid,
  input wire logic [7:0] i_opcode,
  output logic o_fetch_ready,
  // Branch outcome, sampled with the opcode
  input wire logic i_branch_taken,
  // Operands for the nibble exchange
  input wire logic [7:0] i_acc,
  input wire logic [7:0] i_ram_byte,
  // Sequencing status
  output logic o_busy,
  output logic o_retire,
  output instr_t o_instr,
  // Stack
  output logic [7:0] o_stack_pointer,
  output logic o_stack_write,
  output logic o_stack_read,
  // Nibble exchange result
  output nibble_xchg_t o_xchd,
  output logic o_xchd_valid
);

  function automatic timing_info_t t_of(
    input logic [1:0] b,
    input logic [3:0] c,
    input logic cond
  );
    timing_info_t r;
    r.bytes = b;
    r.cycles = c;
    r.cond = cond;
    return r;
  endfunction

  // Cycles given are the not-taken figure for branches
  function automatic timing_info_t decode_timing(
    input logic [7:0] op
  );
    timing_info_t r;
    r = t_of(2'd1, 4'h1, 1'b0);
    casez (op)
      8'h?1: r = t_of(2'd2, 4'h3, 1'b0);
      8'h02, 8'h12: r = t_of(2'd3, 4'h4, 1'b0);
      8'h22, 8'h32: r = t_of(2'd1, 4'h5, 1'b0);
      // Code read relative to A
      8'h73, 8'h83, 8'h93: r = t_of(2'd1, 4'h3, 1'b0);
      // External data both ways
      8'he0, 8'hf0, 8'he2, 8'he3,
      8'hf2, 8'hf3: r = t_of(2'd1, 4'h3, 1'b0);
      8'h80: r = t_of(2'd2, 4'h3, 1'b0);
      // Branch figures are not taken
      8'h10, 8'h20, 8'h30: r = t_of(2'd3, 4'h3, 1'b1);
      8'h40, 8'h50, 8'h60,
      8'h70: r = t_of(2'd2, 4'h2, 1'b1);
      8'hb4: r = t_of(2'd3, 4'h3, 1'b1);
      8'hb5, 8'hb6, 8'hb7: r = t_of(2'd3, 4'h4, 1'b1);
      8'b10111???: r = t_of(2'd3, 4'h3, 1'b1);
      8'b11011???: r = t_of(2'd2, 4'h2, 1'b1);
      8'hd5: r = t_of(2'd3, 4'h3, 1'b1);
      8'ha4: r = t_of(2'd1, 4'h4, 1'b0);
      // Longest instruction
      8'h84: r = t_of(2'd1, CYC_MAX, 1'b0);
      // Three-byte forms, then two-byte two-clock forms
      8'h43, 8'h53, 8'h63, 8'h75, 8'h85,
      8'h90: r = t_of(2'd3, 4'h3, 1'b0);
      8'h76, 8'h77, 8'ha6, 8'ha7, 8'h86,
      8'h87: r = t_of(2'd2, 4'h2, 1'b0);
      // Indirect RAM needs a second clock, then two-byte register forms
      8'b????011?: r = t_of(2'd1, 4'h2, 1'b0);
      8'b01111???, 8'b10101???,
      8'b10001???: r = t_of(2'd2, 4'h2, 1'b0);
      // Working register forms
      8'b????1???: r = t_of(2'd1, 4'h1, 1'b0);
      8'ha5: r = t_of(2'd1, 4'h1, 1'b0);
      // Direct and immediate forms
      8'h?5: r = t_of(2'd2, 4'h2, 1'b0);
      8'h24, 8'h34, 8'h44, 8'h54, 8'h64, 8'h94,
      8'h74: r = t_of(2'd2, 4'h2, 1'b0);
      // A manipulations in one clock; 8'h?2 forms take two
      8'h?4, 8'h?3: r = t_of(2'd1, 4'h1, 1'b0);
      8'h?2: r = t_of(2'd2, 4'h2, 1'b0);
      // 8'ha0 and 8'hb0, then push and pop
      8'ha0, 8'hb0, 8'hc0,
      8'hd0: r = t_of(2'd2, 4'h2, 1'b0);
      // Everything else: clocks equal bytes
      default: r = t_of(2'd1, 4'h1, 1'b0);
    endcase
    return r;
  endfunction

  seq_state_t state_q;
  seq_state_t state_d;
  timing_info_t info;
  logic accept;
  logic take;
  logic [CYC_W-1:0] total;
  logic [CYC_W-1:0] remaining;
  logic last;
  instr_t instr_q;
  logic [7:0] sp_q;
  nibble_xchg_t xchd_q;
  logic xchd_valid_q;
  logic [CYC_W-1:0] busy_cnt_q;

  assign info = decode_timing(i_opcode);
  assign accept = (state_q == ST_FETCH) && i_fetch_valid;
  assign take = info.cond && i_branch_taken;
  // Taken branch costs one clock more
  assign total = info.cycles + (take ? CYC_ONE : '0);

  // Counts in plain clocks
  cycle_countdown #(
    .W(CYC_W)
  ) u_count (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_load(accept),
    .i_count(total),
    .o_remaining(remaining),
    .o_last(last)
  );

  // Fetch waits for the count, then resumes
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_FETCH: begin
        if (accept) begin
          state_d = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (last) begin
          state_d = ST_FETCH;
        end
      end
      default: state_d = ST_FETCH;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      state_q <= ST_FETCH;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      instr_q <= '0;
    end else if (accept) begin
      instr_q.opcode <= i_opcode;
      instr_q.bytes <= info.bytes;
      instr_q.cycles <= total;
      instr_q.taken <= take;
    end
  end

  // Pre-increment on push, so the write sees the new top
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      sp_q <= SP_RESET;
    end else if (accept && i_opcode == OP_PUSH) begin
      sp_q <= sp_q + SP_STEP;
    end else if (o_retire && instr_q.opcode == OP_POP) begin
      sp_q <= sp_q - SP_STEP;
    end
  end

  // Low nibbles only; high nibbles stay put
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      xchd_q <= '0;
      xchd_valid_q <= 1'b0;
    end else begin
      xchd_valid_q <= 1'b0;
      if (o_retire && instr_q.opcode[7:1] == OP_XCHD_HI) begin
        xchd_q.acc <= {i_acc[NIB_HI:NIB_LO],
                       i_ram_byte[NIB_LO-1:0]};
        xchd_q.ram <= {i_ram_byte[NIB_HI:NIB_LO],
                       i_acc[NIB_LO-1:0]};
        xchd_valid_q <= 1'b1;
      end
    end
  end

  // Execute-phase clocks seen so far; checking aid
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      busy_cnt_q <= '0;
    end else if (accept) begin
      busy_cnt_q <= '0;
    end else if (o_busy) begin
      busy_cnt_q <= busy_cnt_q + CYC_ONE;
    end
  end

  assign o_fetch_ready = (state_q == ST_FETCH);
  assign o_busy = (state_q == ST_EXEC);
  assign o_retire = o_busy && last;
  assign o_instr = instr_q;
  assign o_stack_pointer = sp_q;
  assign o_stack_write = o_retire && instr_q.opcode == OP_PUSH;
  // Pop reads before the pointer drops
  assign o_stack_read = o_retire && instr_q.opcode == OP_POP;
  assign o_xchd = xchd_q;
  assign o_xchd_valid = xchd_valid_q;

  AST_CLOCKS_EQUAL_COUNT: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_retire |-> (busy_cnt_q + CYC_ONE) == o_instr.cycles
  ) else $error("execute length differs from cycle count");

  AST_BYTES_EQUAL_CLOCKS: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && i_opcode[7:4] == 4'h2 && i_opcode[3:0] > 4'h2
      && i_opcode[3:1] != 3'b011
      |=> o_instr.cycles == {2'b00, o_instr.bytes}
  ) else $error("plain add does not take clocks equal to bytes");

  AST_BRANCH_TAKEN_PLUS_ONE: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && (i_opcode == 8'h40 || i_opcode == 8'h60)
      |=> o_instr.cycles
        == ($past(i_branch_taken) ? 4'h3 : 4'h2)
  ) else $error("branch length wrong for its outcome");

  AST_WORKING_REG_ONE: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && i_opcode[7:3] == 5'b00101
      |=> o_retire ##1 o_fetch_ready
  ) else $error("register add did not finish in one clock");

  AST_INDIRECT_TWO: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && i_opcode[7:1] == 7'h13
      |=> !o_retire ##1 o_retire
  ) else $error("indirect add did not take two clocks");

  AST_DIRECT_IMM_TWO: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && (i_opcode == 8'h24 || i_opcode == 8'h25)
      |=> !o_retire ##1 o_retire ##0 o_instr.bytes == 2'd2
  ) else $error("direct or immediate add wrong");

  AST_LOGIC_IMM_THREE: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && (i_opcode == 8'h43 || i_opcode == 8'h53
      || i_opcode == 8'h63)
      |=> !o_retire [*2] ##1 o_retire
  ) else $error("logic immediate to direct not three clocks");

  AST_ACC_MANIP_ONE: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && (i_opcode == 8'he4 || i_opcode == 8'hf4
      || i_opcode == 8'hc4 || i_opcode == 8'h23)
      |=> o_retire
  ) else $error("accumulator manipulation not one clock");

  AST_CODE_READ_THREE: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && (i_opcode == 8'h93 || i_opcode == 8'h83)
      |=> o_busy [*3] ##0 o_retire ##1 o_fetch_ready
  ) else $error("code read not three clocks");

  AST_EXT_DATA_THREE: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && i_opcode[7:5] == 3'b111
      && (i_opcode[3:0] == 4'h0 || i_opcode[3:1] == 3'b001)
      |=> !o_retire [*2] ##1 o_retire
  ) else $error("external data access not three clocks");

  AST_DIRECT_COPY_THREE: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && i_opcode == 8'h85
      |=> o_instr.bytes == 2'd3 && o_instr.cycles == 4'h3
  ) else $error("direct copy timing wrong");

  AST_POINTER_LOAD_THREE: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && i_opcode == 8'h90
      |=> !o_retire [*2] ##1 o_retire
  ) else $error("data pointer load not three clocks");

  AST_STORE_INDIRECT_TWO: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && i_opcode[7:1] == 7'h7b
      |=> !o_retire ##1 o_retire
  ) else $error("indirect store not two clocks");

  AST_STACK_TWO: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && (i_opcode == OP_PUSH || i_opcode == OP_POP)
      |=> !o_retire ##1 o_retire
        && (o_stack_write || o_stack_read)
  ) else $error("push or pop not two clocks");

  AST_XCHD_LOW_NIBBLE: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_retire && o_instr.opcode[7:1] == OP_XCHD_HI |=>
      o_xchd_valid
      && o_xchd.acc == {$past(i_acc[7:4]), $past(i_ram_byte[3:0])}
      && o_xchd.ram == {$past(i_ram_byte[7:4]), $past(i_acc[3:0])}
  ) else $error("nibble exchange result wrong");

  AST_XCH_REG_ONE: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && i_opcode[7:3] == 5'b11001 |=> o_retire
  ) else $error("register exchange not one clock");

  AST_EIGHT_MAX: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_busy |-> busy_cnt_q < CYC_MAX && remaining <= CYC_MAX
  ) else $error("instruction exceeded eight clocks");

  AST_PUSH_PREINC: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && i_opcode == OP_PUSH |=>
      o_stack_pointer == $past(o_stack_pointer) + SP_STEP
      ##1 o_stack_write && $stable(o_stack_pointer)
  ) else $error("push stored before stack pointer rose");

  AST_FETCH_AFTER_RETIRE: assert property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_retire |=> o_fetch_ready && !o_busy
  ) else $error("fetch did not resume after retire");

  COV_BRANCH_TAKEN: cover property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && take
  );

  COV_BRANCH_NOT_TAKEN: cover property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    accept && info.cond && !take
  );

  COV_DIVIDE: cover property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_retire && o_instr.cycles == CYC_MAX
  );

  COV_BACK_TO_BACK: cover property (
    @(posedge i_mclk) disable iff (!i_rst_n)
    o_retire ##1 accept
  );

endmodule

// [test/code_mem_model.sv]
// Code memory and data RAM model facing the sequencer's fetch side.
// Assumes the bench pulses i_offer for one clock per opcode.
`timescale 1ns/1ps
module code_mem_model (
  // Clock
  input wire logic i_mclk,
  // Bench requests
  input wire logic i_offer,
  input wire logic [7:0] i_op,
  input wire logic i_taken,
  input wire logic [7:0] i_acc_val,
  input wire logic [7:0] i_ram_val,
  // Fetch side
  input wire logic i_fetch_ready,
  output logic o_fetch_valid,
  output logic [7:0] o_opcode,
  output logic o_branch_taken,
  output logic [7:0] o_acc,
  output logic [7:0] o_ram_byte
);
  logic took_q;

  assign o_acc = i_acc_val;
  assign o_ram_byte = i_ram_val;

  initial begin
    o_fetch_valid = 1'b0;
    o_opcode = 8'h00;
    o_branch_taken = 1'b0;
    took_q = 1'b0;
  end

  always @(posedge i_mclk) begin
    took_q <= o_fetch_valid && i_fetch_ready;
  end

  // Offer held until taken; idle lines flip so stale data never matches
  always @(negedge i_mclk) begin
    if (!o_fetch_valid || took_q) begin
      o_fetch_valid <= i_offer;
      o_opcode <= i_offer ? i_op : ~o_opcode;
      o_branch_taken <= i_offer ? i_taken : ~o_branch_taken;
    end
  end
endmodule

// [test/test_instr_sequencer.sv]
// Bench for the instruction cycle sequencer: opcode timing table,
// refused early offer, stack and nibble exchange side effects.
// Assumes the code memory model drives the whole fetch side.
`timescale 1ns/1ps
module test_instr_sequencer
  import timing_pkg::*;
;
  localparam logic [7:0] ACC_V = 8'h5a;
  localparam logic [7:0] RAM_V = 8'hc3;
  logic mclk;
  logic rst_n;
  logic offer;
  logic [7:0] req_op;
  logic req_tk;
  logic fetch_valid;
  logic [7:0] opcode;
  logic fetch_ready;
  logic branch_taken;
  logic [7:0] acc;
  logic [7:0] ram_byte;
  logic busy;
  logic retire;
  instr_t instr;
  logic [7:0] sp;
  logic st_wr;
  logic st_rd;
  nibble_xchg_t xchd;
  logic xchd_valid;
  int n_mismatch = 0;
  int checked = 0;
  logic [7:0] sp_exp = SP_RESET;
  // Opcode, then cond flag and byte count, then clock count
  logic [15:0] tbl [32] = '{
    16'h2811, 16'h2612, 16'h2522, 16'h2422,
    16'h5333, 16'h4333, 16'h6333,
    16'he411, 16'hf411, 16'h2311, 16'h3311,
    16'h0311, 16'h1311, 16'hc411,
    16'h9313, 16'h8313,
    16'he213, 16'hf213, 16'he013, 16'hf013,
    16'h8533, 16'h9033, 16'hf612,
    16'hc022, 16'hd022, 16'hd612, 16'hd712,
    16'hc811, 16'h8418,
    16'h40a2, 16'h60a2, 16'hb4b3
  };

  instr_sequencer i_dut (
    .i_mclk(mclk), .i_rst_n(rst_n),
    .i_fetch_valid(fetch_valid), .i_opcode(opcode),
    .o_fetch_ready(fetch_ready), .i_branch_taken(branch_taken),
    .i_acc(acc), .i_ram_byte(ram_byte),
    .o_busy(busy), .o_retire(retire), .o_instr(instr),
    .o_stack_pointer(sp), .o_stack_write(st_wr), .o_stack_read(st_rd),
    .o_xchd(xchd), .o_xchd_valid(xchd_valid)
  );

  code_mem_model i_mem (
    .i_mclk(mclk), .i_offer(offer), .i_op(req_op), .i_taken(req_tk),
    .i_acc_val(ACC_V), .i_ram_val(RAM_V), .i_fetch_ready(fetch_ready),
    .o_fetch_valid(fetch_valid), .o_opcode(opcode),
    .o_branch_taken(branch_taken), .o_acc(acc), .o_ram_byte(ram_byte)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
      input string what);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what,
        seen, exp);
    end
  endtask

  task automatic results();
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic offer_op(input logic [7:0] op, input logic tk);
    @(negedge mclk);
    offer <= 1'b1;
    req_op <= op;
    req_tk <= tk;
    @(negedge mclk);
    offer <= 1'b0;
  endtask

  // Rising edges up to and including the accept edge
  task automatic wait_accept(output int k);
    k = 0;
    do begin
      @(posedge mclk);
      k++;
      if (k > 40) begin
        n_mismatch++;
        results();
      end
    end while (!(fetch_valid && fetch_ready));
  endtask

  task automatic exec(input logic [15:0] e, input logic tk);
    logic [7:0] op;
    logic cond;
    logic xd;
    int n;
    op = e[15:8];
    cond = e[7];
    xd = (op[7:1] == OP_XCHD_HI);
    n = 0;
    if (op == OP_PUSH) sp_exp++;
    do begin
      @(negedge mclk);
      n++;
      check(8'(busy), 8'h01, "busy");
      check(8'(fetch_ready), 8'h00, "ready in exec");
      check(sp, sp_exp, "stack pointer");
      if (n > 9) begin
        n_mismatch++;
        results();
      end
    end while (retire !== 1'b1);
    check(n[7:0], 8'(e[3:0]) + 8'(cond & tk), "clocks");
    check(instr.opcode, op, "opcode");
    check(8'(instr.bytes), 8'(e[5:4]), "bytes");
    if (!cond) check(8'(instr.cycles), 8'(e[3:0]), "cycle field");
    else check(8'(instr.taken), 8'(tk), "taken");
    check(8'(st_wr), 8'(op == OP_PUSH), "push strobe");
    check(8'(st_rd), 8'(op == OP_POP), "pop strobe");
    if (op == OP_POP) sp_exp--;
    @(negedge mclk);
    check(8'(fetch_ready), 8'h01, "ready after");
    check(8'(busy), 8'h00, "busy after");
    check(sp, sp_exp, "stack pointer after");
    check(8'(xchd_valid), 8'(xd), "exchange valid");
    if (xd) begin
      check(xchd.acc, {ACC_V[7:4], RAM_V[3:0]}, "acc nibble");
      check(xchd.ram, {RAM_V[7:4], ACC_V[3:0]}, "ram nibble");
    end
  endtask

  initial begin
    int k;
    rst_n = 1'b0;
    offer = 1'b0;
    req_op = 8'h00;
    req_tk = 1'b0;
    repeat (10) @(negedge mclk);
    check(sp, SP_RESET, "reset stack pointer");
    check(8'(busy), 8'h00, "reset busy");
    check(8'(fetch_ready), 8'h01, "reset ready");
    rst_n = 1'b1;
    foreach (tbl[i]) begin
      for (int t = 0; t <= int'(tbl[i][7]); t++) begin
        offer_op(tbl[i][15:8], t[0]);
        wait_accept(k);
        exec(tbl[i], t[0]);
      end
    end
    // Longest op with the next opcode offered while it runs
    offer_op(8'h84, 1'b0);
    wait_accept(k);
    fork
      exec(16'h8418, 1'b0);
      offer_op(8'hc8, 1'b0);
    join
    wait_accept(k);
    check(k[7:0], 8'h01, "accept after retire");
    exec(16'hc811, 1'b0);
    results();
  end
endmodule
